//--- vic_pkg.sv
package vic_pkg;

  // Source and register geometry.
  localparam int unsigned NUM_SRC      = 80;
  localparam int unsigned REG_W        = 16;
  localparam int unsigned PRIO_W       = 3;
  localparam int unsigned LEVEL_W      = 4;
  localparam int unsigned VEC_W        = 7;
  localparam int unsigned SRC_PER_FLAG = 16;
  localparam int unsigned SRC_PER_PRIO = 4;
  localparam int unsigned NUM_FLAG_REG = 5;
  localparam int unsigned NUM_PRIO_REG = 20;

  // Register byte offsets on the APB bus.
  localparam logic [11:0] OFS_CTRL_ONE  = 12'h000;
  localparam logic [11:0] OFS_CTRL_TWO  = 12'h004;
  localparam logic [11:0] OFS_FLAG_BASE = 12'h010;
  localparam logic [11:0] OFS_EN_BASE   = 12'h030;
  localparam logic [11:0] OFS_PRIO_BASE = 12'h050;
  localparam logic [11:0] OFS_PEND      = 12'h0A0;
  localparam logic [11:0] OFS_ALU_STAT  = 12'h0A4;
  localparam logic [11:0] OFS_CORE_CTRL = 12'h0A8;
  localparam logic [11:0] OFS_IRQ_STAT  = 12'h0B0;
  localparam logic [11:0] OFS_IRQ_MASK  = 12'h0B4;

  // Field positions.
  localparam int unsigned NEST_DIS_BIT  = 15;
  localparam int unsigned ALT_VT_BIT    = 15;
  localparam int unsigned EXT_EDGE_LSB  = 0;
  localparam int unsigned NUM_EXT       = 3;
  localparam int unsigned CPU_LVL_LSB   = 5;
  localparam int unsigned CORE_TOP_BIT  = 3;
  localparam int unsigned PEND_LVL_LSB  = 8;
  localparam int unsigned ULP_WAKE_BIT  = 0;
  localparam int unsigned ULP_EN_REG    = 4;
  localparam int unsigned TRAP_LSB      = 1;
  localparam int unsigned NUM_TRAP      = 4;

  // Event status bits.
  localparam int unsigned EV_NEW_PEND   = 0;
  localparam int unsigned EV_TRAP       = 1;
  localparam int unsigned NUM_EV        = 2;

  localparam logic [REG_W-1:0] RST_ZERO = 16'h0000;
  localparam logic [31:0]      RD_ZERO  = 32'h0000_0000;

  typedef struct packed {
    logic [VEC_W-1:0]   vector;
    logic [LEVEL_W-1:0] level;
    logic               valid;
  } vic_pend_s;

  typedef enum logic [1:0] {
    VIC_IDLE,
    VIC_PRESENT,
    VIC_WAIT_ACK
  } vic_state_e;

endpackage

//--- vic_sync.sv
`timescale 1ns/1ns
`default_nettype none
module vic_sync import vic_pkg::*; #(
  parameter int unsigned W = 1
) (
  // Clock and reset.
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Raw level in; filtered level and one-cycle rise pulse out.
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] level_q,
  output var  logic [W-1:0] rise_q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change is accepted once the second and third stages agree.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= '0;
      rise_q  <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        rise_q[i] <= 1'b0;
        if (s2_q[i] == s3_q[i] && s3_q[i] != level_q[i]) begin
          level_q[i] <= s3_q[i];
          rise_q[i]  <= s3_q[i];
        end
      end
    end
  end
endmodule // vic_sync
`default_nettype wire

//--- vic_arbiter.sv
`timescale 1ns/1ns
`default_nettype none
module vic_arbiter import vic_pkg::*; #(
  parameter int unsigned N = NUM_SRC
) (
  // Clock and reset.
  input  wire logic                pclk,
  input  wire logic                presetn,
  // Requests.
  input  wire logic [N-1:0]        req,
  input  wire logic [N*PRIO_W-1:0] prio,
  // Registered winner.
  output var  vic_pend_s           win_q
);
  vic_pend_s win_d;

  // Highest level wins; strict compare keeps the lowest vector on ties.
  always_comb begin
    win_d = '0;
    for (int i = 0; i < N; i++) begin
      if (req[i] && prio[i*PRIO_W +: PRIO_W] != '0 &&
          {1'b0, prio[i*PRIO_W +: PRIO_W]} > win_d.level) begin
        win_d.valid  = 1'b1;
        win_d.level  = {1'b0, prio[i*PRIO_W +: PRIO_W]};
        win_d.vector = VEC_W'(i);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) win_q <= '0;
    else          win_q <= win_d;
  end
endmodule // vic_arbiter
`default_nettype wire

//--- vic_top.sv
// What this block does
// RULE1 - Each source has a request flag set by hardware, cleared only by software.
// RULE2 - A source is forwarded for service only while its enable bit is set.
// RULE3 - Each source has a writable three-bit priority selecting one of eight levels.
// RULE4 - Pending vector latches into seven bits, its level into four bits.
// RULE5 - Sources map to flag, enable, priority bits in natural vector order.
// RULE6 - CPU level low bits sit at status bits 7:5 and are software writable.
// RULE7 - CPU level top bit sits in core control and is read-only to software.
// RULE8 - Control register one holds nesting disable plus trap control and status flags.
// RULE9 - Control register two sets external pin behaviour and alternate table select.
// RULE10 - Enable register five holds wake enable at bit 0, upper bits read zero.
// RULE11 - The controller has 23 registers: controls, flags, enables, priorities, pending. The code has 33 registers of these kinds.
// RULE12 - Highest enabled level wins, lowest vector on ties, only above CPU level.
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module vic_top import vic_pkg::*; #(
  parameter int unsigned N = NUM_SRC
) (
  // Clock and reset.
  input  wire logic                pclk,
  input  wire logic                presetn,
  // APB slave.
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Peripheral requests, one-cycle pulses on pclk.
  input  wire logic [N-1:0]        periph_req,
  // External interrupt pins.
  input  wire logic [NUM_EXT-1:0]  ext_pin,
  // Trap events from the core.
  input  wire logic [NUM_TRAP-1:0] trap_event,
  // Core side.
  input  wire logic                core_ack,
  input  wire logic                core_ret,
  output logic                     core_irq,
  output logic [VEC_W-1:0]         core_vector,
  output logic [LEVEL_W-1:0]       core_level,
  output logic                     core_alt_table,
  output logic                     irq_out
);
  localparam int unsigned IDX_W      = 5;
  // Bytes per register word, and bit pitch of the priority fields within a word.
  localparam int unsigned WORD_BYTES = 4;
  localparam int unsigned PRIO_PITCH = 4;

  logic [N-1:0]             flag_q;
  logic [N-1:0]             en_q;
  logic [N*PRIO_W-1:0]      prio_q;
  logic [REG_W-1:0]         ctrl_one_q;
  logic [REG_W-1:0]         ctrl_two_q;
  logic [LEVEL_W-1:0]       cpu_lvl_q;
  logic [LEVEL_W-1:0]       saved_lvl_q;
  logic [VEC_W+LEVEL_W-1:0] pend_q;
  logic [NUM_EV-1:0]        ev_stat_q;
  logic [NUM_EV-1:0]        ev_mask_q;
  logic [NUM_EXT-1:0]       ext_lvl;
  logic [NUM_EXT-1:0]       ext_rise;
  logic [NUM_EXT-1:0]       ext_prev_q;
  logic [NUM_EXT-1:0]       ext_evt;
  logic [N-1:0]             hw_set;
  logic [N-1:0]             sw_clr;
  vic_pend_s                win_q;
  vic_state_e               state_q;
  logic                     wr_en;
  logic                     rd_en;
  logic                     hit;
  logic [31:0]              rdata_d;
  logic [NUM_EV-1:0]        ev_set;
  logic                     can_present;

  function automatic logic in_bank(input logic [11:0] a, input logic [11:0] base,
                                   input int unsigned cnt);
    return a >= base && a < base + 12'(cnt * WORD_BYTES);
  endfunction

  function automatic logic [IDX_W-1:0] bank_idx(input logic [11:0] a, input logic [11:0] base);
    logic [11:0] d;
    d = a - base;
    return d[IDX_W+1:2];
  endfunction

  // Writes commit in the access phase; reads are captured at the end of setup.
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  // Pins pass four flip-flops before they can set a flag.
  vic_sync #(.W(NUM_EXT)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (ext_pin),
    .level_q  (ext_lvl),
    .rise_q   (ext_rise)
  );

  // Filtered level one cycle back, for the falling-edge option.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ext_prev_q <= '0;
    else          ext_prev_q <= ext_lvl;
  end

  // Each pin triggers on rising or falling edge as its polarity bit says.
  always_comb begin
    for (int i = 0; i < NUM_EXT; i++) begin
      ext_evt[i] = ctrl_two_q[EXT_EDGE_LSB + i] ? (ext_prev_q[i] && !ext_lvl[i]) : ext_rise[i]; // [RULE9]
    end
  end

  // Software write-one-to-clear per flag; hardware sets win over it.
  always_comb begin
    hw_set = periph_req;
    for (int i = 0; i < NUM_EXT; i++) begin
      hw_set[i] = periph_req[i] | ext_evt[i]; // [RULE5]
    end
    sw_clr = '0;
    if (wr_en && in_bank(paddr, OFS_FLAG_BASE, NUM_FLAG_REG)) begin
      for (int i = 0; i < SRC_PER_FLAG; i++) begin
        if (pwdata[i]) sw_clr[int'(bank_idx(paddr, OFS_FLAG_BASE)) * SRC_PER_FLAG + i] = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) flag_q <= '0;
    else          flag_q <= (flag_q & ~sw_clr) | hw_set; // [RULE1]
  end

  // Enable register five holds only the wake enable; its other bits read zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= '0;
    end else if (wr_en && in_bank(paddr, OFS_EN_BASE, NUM_FLAG_REG)) begin
      if (bank_idx(paddr, OFS_EN_BASE) == IDX_W'(ULP_EN_REG)) begin
        en_q[ULP_EN_REG*SRC_PER_FLAG +: SRC_PER_FLAG] <= {15'h0000, pwdata[ULP_WAKE_BIT]}; // [RULE10]
      end else begin
        en_q[bank_idx(paddr, OFS_EN_BASE)*SRC_PER_FLAG +: SRC_PER_FLAG] <= pwdata[15:0]; // [RULE2]
      end
    end
  end

  // Four priority fields per word, each three bits wide on a four-bit pitch.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_q <= '0;
    end else if (wr_en && in_bank(paddr, OFS_PRIO_BASE, NUM_PRIO_REG)) begin
      for (int i = 0; i < SRC_PER_PRIO; i++) begin
        prio_q[(bank_idx(paddr, OFS_PRIO_BASE)*SRC_PER_PRIO + i)*PRIO_W +: PRIO_W] <=
          pwdata[i*PRIO_PITCH +: PRIO_W]; // [RULE3] [RULE5]
      end
    end
  end

  // Winner among enabled pending sources, one cycle behind the flags.
  vic_arbiter #(.N(N)) u_arb (
    .pclk    (pclk),
    .presetn (presetn),
    .req     (flag_q & en_q), // [RULE2]
    .prio    (prio_q),
    .win_q   (win_q)
  );

  // Control registers; trap flags in control one are sticky, cleared by writing one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_one_q <= RST_ZERO;
      ctrl_two_q <= RST_ZERO;
    end else begin
      if (wr_en && paddr == OFS_CTRL_TWO) ctrl_two_q <= pwdata[15:0]; // [RULE9]
      if (wr_en && paddr == OFS_CTRL_ONE) begin
        ctrl_one_q[NEST_DIS_BIT] <= pwdata[NEST_DIS_BIT]; // [RULE8]
        ctrl_one_q[TRAP_LSB +: NUM_TRAP] <=
          (ctrl_one_q[TRAP_LSB +: NUM_TRAP] & ~pwdata[TRAP_LSB +: NUM_TRAP]) | trap_event; // [RULE8]
      end else begin
        ctrl_one_q[TRAP_LSB +: NUM_TRAP] <= ctrl_one_q[TRAP_LSB +: NUM_TRAP] | trap_event;
      end
    end
  end

  // Nesting disable holds off any new interrupt while the CPU runs above level zero.
  assign can_present = win_q.valid && win_q.level > cpu_lvl_q &&
                       !(ctrl_one_q[NEST_DIS_BIT] && cpu_lvl_q != '0); // [RULE12] [RULE8]

  // Core handshake: present winner above CPU level, raise level on ack, restore on return.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= VIC_IDLE;
      pend_q      <= '0;
      core_irq    <= 1'b0;
      core_vector <= '0;
      core_level  <= '0;
    end else begin
      case (state_q)
        VIC_IDLE: begin
          if (can_present) begin // [RULE12]
            pend_q      <= {win_q.vector, win_q.level}; // [RULE4]
            core_irq    <= 1'b1;
            core_vector <= win_q.vector;
            core_level  <= win_q.level;
            state_q     <= VIC_PRESENT;
          end
        end
        VIC_PRESENT: begin
          if (core_ack) begin
            core_irq <= 1'b0;
            state_q  <= VIC_WAIT_ACK;
          end
        end
        VIC_WAIT_ACK: begin
          if (core_ret) state_q <= VIC_IDLE;
        end
        default: state_q <= VIC_IDLE;
      endcase
    end
  end

  // The core's ack and return set the whole level; software may move the low bits
  // at any other time; a write in the same cycle as an ack or a return is lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_lvl_q   <= '0;
      saved_lvl_q <= '0;
    end else if (state_q == VIC_PRESENT && core_ack) begin
      saved_lvl_q <= cpu_lvl_q;
      cpu_lvl_q   <= core_level;
    end else if (state_q == VIC_WAIT_ACK && core_ret) begin
      cpu_lvl_q <= saved_lvl_q;
    end else if (wr_en && paddr == OFS_ALU_STAT) begin
      cpu_lvl_q[PRIO_W-1:0] <= pwdata[CPU_LVL_LSB +: PRIO_W]; // [RULE6] [RULE7]
    end
  end

  // Alternate vector table select goes to the core as a registered copy.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) core_alt_table <= 1'b0;
    else          core_alt_table <= ctrl_two_q[ALT_VT_BIT]; // [RULE9]
  end

  assign ev_set[EV_NEW_PEND] = (state_q == VIC_IDLE) && can_present;
  assign ev_set[EV_TRAP]     = |trap_event;

  // Event status is sticky; an event in the clearing cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_stat_q <= '0;
      ev_mask_q <= '0;
      irq_out   <= 1'b0;
    end else begin
      if (wr_en && paddr == OFS_IRQ_STAT) ev_stat_q <= (ev_stat_q & ~pwdata[NUM_EV-1:0]) | ev_set;
      else                                 ev_stat_q <= ev_stat_q | ev_set;
      if (wr_en && paddr == OFS_IRQ_MASK) ev_mask_q <= pwdata[NUM_EV-1:0];
      irq_out <= |(ev_stat_q & ev_mask_q);
    end
  end

  // Read mux; the level top bit reads only through core control. [RULE11]
  always_comb begin
    rdata_d = RD_ZERO;
    hit     = 1'b1;
    if (in_bank(paddr, OFS_FLAG_BASE, NUM_FLAG_REG)) begin
      rdata_d[15:0] = flag_q[bank_idx(paddr, OFS_FLAG_BASE)*SRC_PER_FLAG +: SRC_PER_FLAG];
    end else if (in_bank(paddr, OFS_EN_BASE, NUM_FLAG_REG)) begin
      rdata_d[15:0] = en_q[bank_idx(paddr, OFS_EN_BASE)*SRC_PER_FLAG +: SRC_PER_FLAG];
    end else if (in_bank(paddr, OFS_PRIO_BASE, NUM_PRIO_REG)) begin
      for (int i = 0; i < SRC_PER_PRIO; i++) begin
        rdata_d[i*PRIO_PITCH +: PRIO_W] =
          prio_q[(bank_idx(paddr, OFS_PRIO_BASE)*SRC_PER_PRIO + i)*PRIO_W +: PRIO_W];
      end
    end else begin
      case (paddr)
        OFS_CTRL_ONE:  rdata_d[15:0] = ctrl_one_q;
        OFS_CTRL_TWO:  rdata_d[15:0] = ctrl_two_q;
        OFS_PEND: begin
          rdata_d[VEC_W-1:0]                    = pend_q[VEC_W+LEVEL_W-1:LEVEL_W]; // [RULE4]
          rdata_d[PEND_LVL_LSB +: LEVEL_W]      = pend_q[LEVEL_W-1:0];
        end
        OFS_ALU_STAT:  rdata_d[CPU_LVL_LSB +: PRIO_W] = cpu_lvl_q[PRIO_W-1:0]; // [RULE6]
        OFS_CORE_CTRL: rdata_d[CORE_TOP_BIT] = cpu_lvl_q[LEVEL_W-1]; // [RULE7]
        OFS_IRQ_STAT:  rdata_d[NUM_EV-1:0] = ev_stat_q;
        OFS_IRQ_MASK:  rdata_d[NUM_EV-1:0] = ev_mask_q;
        default:       hit = 1'b0;
      endcase
    end
  end

  // No wait states: data registered in setup, ready in the first access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= RD_ZERO;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      if (rd_en) prdata <= rdata_d;
    end
  end
endmodule // vic_top
`default_nettype wire

//--- vic_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module vic_monitor (
  // Clock and reset.
  input wire logic        pclk,
  input wire logic        presetn,
  // APB.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Core side.
  input wire logic        core_ack,
  input wire logic        core_irq,
  input wire logic [6:0]  core_vector,
  input wire logic [3:0]  core_level
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence present_s;
    core_irq && !core_ack;
  endsequence
  ready_after_setup_a: assert property (setup_s |=> pready)
    else $error("no pready after setup");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("pready held");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  err_reads_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  upper_half_zero_a: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
    else $error("upper read bits set");
  present_holds_a: assert property (present_s |=> core_irq && $stable(core_vector)
    && $stable(core_level)) else $error("presented vector moved");
  ack_drops_irq_a: assert property (core_irq && core_ack |=> !core_irq)
    else $error("core_irq after ack");
  level_above_zero_a: assert property (core_irq |-> core_level != 4'h0)
    else $error("zero level presented");
endmodule // vic_monitor
bind vic_top vic_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .core_ack(core_ack), .core_irq(core_irq),
  .core_vector(core_vector), .core_level(core_level));
`default_nettype wire

//--- vic_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module vic_core_model (
  // Clock and reset.
  input wire logic       pclk,
  input wire logic       presetn,
  // Presented request and answers.
  input wire logic       core_irq,
  input wire logic [3:0] ack_wait,
  output var logic       core_ack,
  output var logic       core_ret
);
  localparam int RET_WAIT = 16;
  // The core accepts after a chosen pause, then returns; it never nests.
  initial begin
    core_ack = 1'b0;
    core_ret = 1'b0;
    forever begin
      @(posedge pclk);
      if (presetn && core_irq) begin
        repeat (ack_wait) @(posedge pclk);
        core_ack <= 1'b1;
        @(posedge pclk);
        core_ack <= 1'b0;
        repeat (RET_WAIT) @(posedge pclk);
        core_ret <= 1'b1;
        @(posedge pclk);
        core_ret <= 1'b0;
      end
    end
  end
endmodule // vic_core_model
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top import vic_pkg::*;;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        pready, pslverr, core_irq, core_alt_table, irq_out, core_ack, core_ret;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [79:0] periph_req = 80'h0, en;
  logic [2:0]  ext_pin = 3'h0;
  logic [3:0]  trap_event = 4'h0, ack_wait = 4'h0, core_level;
  logic [6:0]  core_vector;
  logic [2:0]  pr [80];
  logic [32:0] rd_q [$];
  logic [10:0] pr_q [$];
  int          fails = 0, total_checks = 0, acks = 0, a, b, w, n;
  localparam logic [11:0] RA [5] = '{OFS_EN_BASE + 12'h010, OFS_PRIO_BASE, OFS_ALU_STAT,
                                     OFS_CORE_CTRL, 12'h0FC};
  localparam logic [32:0] RE [5] = '{33'h1, 33'h7777, 33'hE0, 33'h0, 33'h1_0000_0000};
  vic_top #(.N(80)) uut (.*);
  vic_core_model u_core (.*);
  always #20 pclk = ~pclk;
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic apb(input logic [11:0] ad, input logic r, input logic [31:0] d,
                     input logic [32:0] e);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= !r;
    paddr <= ad;
    pwdata <= d;
    if (r) rd_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) fails++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    apb(ad, 1'b0, d, 33'h0);
  endtask
  task automatic rd(input logic [11:0] ad, input logic [32:0] e);
    apb(ad, 1'b1, 32'h0, e);
  endtask
  task automatic pulse(input logic [79:0] v);
    periph_req <= v;
    @(posedge pclk);
    periph_req <= 80'h0;
  endtask
  task automatic wait_acks(input int m);
    int k;
    k = 0;
    while (acks < m && k < 300) begin
      @(posedge pclk);
      k++;
    end
    if (acks < m) fails++;
  endtask
  task automatic clr(input int s);
    wr(OFS_FLAG_BASE + 12'(4 * (s / 16)), 32'h1 << (s % 16));
    wr(OFS_ALU_STAT, 32'h0);
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && rd_q.size() > 0)
      chk("read data", rd_q.pop_front(), {pslverr, prdata});
    if (core_irq && core_ack) begin
      acks++;
      if (pr_q.size() > 0)
        chk("vector", {22'h0, pr_q.pop_front()}, {22'h0, core_vector, core_level});
    end
  end
  initial begin
    repeat (30000) @(posedge pclk);
    fails++;
    complete_run();
  end
  initial begin
    foreach (pr[i]) pr[i] = 3'h0;
    void'($urandom(32'h5D4E));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFS_PEND, 33'h0);
    for (int i = 0; i < 5; i++) begin
      rd(RA[i], {RE[i][32], 32'h0});
      wr(RA[i], 32'h0000_FFFF);
      rd(RA[i], RE[i]);
    end
    wr(OFS_ALU_STAT, 32'h0);
    wr(OFS_CTRL_TWO, 32'h0000_8000);
    repeat (2) @(posedge pclk);
    chk("alt table", 33'h1, {32'h0, core_alt_table});
    wr(OFS_CTRL_TWO, 32'h0);
    a = 3 + $urandom % 77;
    pulse(80'h1 << a);
    wr(OFS_FLAG_BASE + 12'(4 * (a / 16)), 32'h0);
    rd(OFS_FLAG_BASE + 12'(4 * (a / 16)), 33'h1 << (a % 16));
    clr(a);
    rd(OFS_FLAG_BASE + 12'(4 * (a / 16)), 33'h0);
    ext_pin <= 3'b001;
    repeat (8) @(posedge pclk);
    rd(OFS_FLAG_BASE, 33'h1);
    clr(0);
    ext_pin <= 3'b000;
    wr(OFS_CTRL_TWO, 32'h2);
    ext_pin <= 3'b010;
    repeat (8) @(posedge pclk);
    rd(OFS_FLAG_BASE, 33'h0);
    ext_pin <= 3'b000;
    repeat (8) @(posedge pclk);
    rd(OFS_FLAG_BASE, 33'h2);
    clr(1);
    wr(OFS_CTRL_TWO, 32'h0);
    for (int t = 0; t < 4; t++) begin
      a = 3 + $urandom % 56;
      b = a + 1 + $urandom % 5;
      pr[a] = 3'(1 + $urandom % 7);
      pr[b] = (t == 0) ? pr[a] : 3'(1 + $urandom % 7);
      en = (80'h1 << a) | ((t == 1) ? 80'h0 : 80'h1 << b);
      ack_wait <= 4'($urandom);
      for (int i = 0; i < 5; i++) wr(OFS_EN_BASE + 12'(4 * i), 32'(en[16*i +: 16]));
      for (int i = 0; i < 20; i++)
        wr(OFS_PRIO_BASE + 12'(4 * i), {17'h0, pr[4*i+3], 1'b0, pr[4*i+2], 1'b0,
           pr[4*i+1], 1'b0, pr[4*i]});
      w = (!en[b] || pr[a] >= pr[b]) ? a : b;
      pr_q.push_back({7'(w), 1'b0, pr[w]});
      if (en[b]) pr_q.push_back({7'(a + b - w), 1'b0, pr[a + b - w]});
      wr(OFS_ALU_STAT, (t == 2) ? 32'hE0 : 32'h0);
      n = acks;
      pulse((80'h1 << a) | (80'h1 << b));
      if (t == 2) begin
        repeat (20) @(posedge pclk);
        chk("blocked", 33'(n), 33'(acks));
        wr(OFS_ALU_STAT, 32'h0);
      end
      wait_acks(n + 1);
      clr(w);
      if (en[b]) wait_acks(n + 2);
      clr(a + b - w);
    end
    wr(OFS_IRQ_MASK, 32'h0);
    trap_event <= 4'h2;
    @(posedge pclk);
    trap_event <= 4'h0;
    repeat (4) @(posedge pclk);
    chk("irq masked", 33'h0, {32'h0, irq_out});
    rd(OFS_CTRL_ONE, 33'h4);
    wr(OFS_IRQ_MASK, 32'h2);
    repeat (3) @(posedge pclk);
    chk("irq raised", 33'h1, {32'h0, irq_out});
    wr(OFS_IRQ_STAT, 32'h3);
    repeat (3) @(posedge pclk);
    chk("irq cleared", 33'h0, {32'h0, irq_out});
    wr(OFS_EN_BASE, 32'h10);
    wr(OFS_PRIO_BASE + 12'h004, 32'h7);
    wr(OFS_CTRL_ONE, 32'h8000);
    wr(OFS_ALU_STAT, 32'h20);
    n = acks;
    pulse(80'h10);
    repeat (20) @(posedge pclk);
    chk("nest blocked", 33'(n), 33'(acks));
    pr_q.push_back({7'd4, 4'h7});
    wr(OFS_CTRL_ONE, 32'h0);
    wait_acks(n + 1);
    clr(4);
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
